// ---- design/memory_to_memory_move.sv ----
// memory-to-memory move engine of the script processor
// Functional notes
// RL1: copy exactly count bytes, source to destination
// RL2: any count up to 16 MB
// RL3: low two address bits differ: illegal
// RL4: program aligns A(3-0) for long bursts
// RL5: addresses direct only, no indirection
// RL6: burst read into FIFO, then written out
// RL7: repeat until zero, then fetch next
// RL8: reserved bits 29-24 set: illegal
// RL9: count from first word bits 23-0
// RL10: second word is source address
// RL11: third word is destination address
// RL12: register select: access register by A(6-0)
// RL13: move never writes first-byte-received register
// RL14: register accesses obey same alignment checks
// RL15: program follows move with interrupt/jump
// RL16: operand and data-structure registers hold addresses
// RL17: opcode in bits 31-30 identifies move
// RL18: move opcode value is binary 11
// RL19: zero count: no transfers, fetch next
`timescale 1ns/1ps
`include "mmove_defines.svh"

module memory_to_memory_move #(
  parameter int BURST_WORDS = `MM_BURST_WORDS
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        start,
  input  wire logic [31:0] instr_word0,
  input  wire logic [31:0] instr_word1,
  input  wire logic [31:0] instr_word2,
  output logic             busy,
  output logic             next_fetch,
  output logic             illegal_instr,
  output logic             mem_req,
  output logic             mem_we,
  output logic [31:0]      mem_addr,
  output logic [3:0]       mem_be,
  output logic [31:0]      mem_wdata,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_ack,
  input  wire logic        reg_sel,
  output logic             reg_re,
  output logic             reg_we,
  output logic [6:0]       reg_addr,
  output logic [31:0]      reg_wdata,
  input  wire logic [31:0] reg_rdata
);

  localparam int BW = $clog2(BURST_WORDS) + 1;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] next_word(input logic [31:0] a);
    next_word = {a[31:2] + 30'h1, 2'h0};
  endfunction

  function automatic logic [2:0] word_nb(input logic [1:0] a,
                                         input logic [23:0] c);
    logic [2:0] room;
    room    = 3'h4 - {1'b0, a};
    word_nb = (c < {21'h0, room}) ? c[2:0] : room;
  endfunction

  function automatic logic [3:0] word_be(input logic [1:0] a,
                                         input logic [23:0] c);
    logic [7:0] lo;
    logic [7:0] hi;
    lo      = 8'h0f << a;
    hi      = 8'hff << ({1'b0, a} + word_nb(a, c));
    word_be = lo[3:0] & ~hi[3:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  mmove_pkg::state_t st_r;
  mmove_pkg::state_t st_nxt;
  logic [31:0]       src_r;
  logic [31:0]       src_nxt;
  logic [31:0]       dst_r;
  logic [31:0]       dst_nxt;
  logic [23:0]       rcnt_r;
  logic [23:0]       rcnt_nxt;
  logic [BW-1:0]     bcnt_r;
  logic [BW-1:0]     bcnt_nxt;
  logic              mem_req_r;
  logic              mem_req_nxt;
  logic              mem_we_r;
  logic              mem_we_nxt;
  logic [31:0]       mem_addr_r;
  logic [31:0]       mem_addr_nxt;
  logic [3:0]        mem_be_r;
  logic [3:0]        mem_be_nxt;
  logic [31:0]       mem_wdata_r;
  logic [31:0]       mem_wdata_nxt;
  logic              reg_re_r;
  logic              reg_re_nxt;
  logic              reg_we_r;
  logic              reg_we_nxt;
  logic [6:0]        reg_addr_r;
  logic [6:0]        reg_addr_nxt;
  logic [31:0]       reg_wdata_r;
  logic [31:0]       reg_wdata_nxt;
  logic              done_r;
  logic              done_nxt;
  logic              illegal_r;
  logic              illegal_nxt;
  logic              busy_r;
  logic              busy_nxt;

  logic                   buf_push;
  logic                   buf_pop;
  logic [`MM_ENTRY_W-1:0] buf_in;
  logic [`MM_ENTRY_W-1:0] buf_head;
  logic                   buf_empty;
  logic                   rd_step;
  logic                   wr_step;
  logic [31:0]            rd_data;
  logic [2:0]             nb;
  logic [23:0]            rcnt_adv;
  logic [31:0]            src_adv;
  logic                   bad;

  burst_buf #(
    .WIDTH (`MM_ENTRY_W),
    .DEPTH (BURST_WORDS)
  ) u_buf (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .push      (buf_push),
    .push_data (buf_in),
    .pop       (buf_pop),
    .head_data (buf_head),
    .full      (),
    .empty     (buf_empty)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    st_nxt        = st_r;
    src_nxt       = src_r;
    dst_nxt       = dst_r;
    rcnt_nxt      = rcnt_r;
    bcnt_nxt      = bcnt_r;
    mem_req_nxt   = mem_req_r;
    mem_we_nxt    = mem_we_r;
    mem_addr_nxt  = mem_addr_r;
    mem_be_nxt    = mem_be_r;
    mem_wdata_nxt = mem_wdata_r;
    reg_re_nxt    = 1'b0;
    reg_we_nxt    = 1'b0;
    reg_addr_nxt  = reg_addr_r;
    reg_wdata_nxt = reg_wdata_r;
    done_nxt      = 1'b0;
    illegal_nxt   = 1'b0;
    buf_pop       = 1'b0;
    rd_step       = 1'b0;
    wr_step       = 1'b0;
    rd_data       = mem_rdata;
    nb            = word_nb(src_r[1:0], rcnt_r);
    rcnt_adv      = rcnt_r - {21'h0, nb};                           // RL1
    src_adv       = next_word(src_r);
    bad = (instr_word0[`MM_OP_HI:`MM_OP_LO] != `MM_OPCODE)   // RL17 RL18
       || (instr_word0[`MM_RSVD_HI:`MM_RSVD_LO] != 6'h00)           // RL8
       || (instr_word1[1:0] != instr_word2[1:0]);                   // RL3 RL14

    unique case (st_r)
      mmove_pkg::ST_IDLE:
      begin
        if (start)
        begin
          src_nxt  = instr_word1;                       // RL10 RL16 RL5
          dst_nxt  = instr_word2;                       // RL11 RL16
          rcnt_nxt = instr_word0[`MM_CNT_HI:0];                     // RL9 RL2
          bcnt_nxt = '0;
          if (bad)
          begin
            illegal_nxt = 1'b1;                                     // RL3 RL8
          end
          else if (instr_word0[`MM_CNT_HI:0] == 24'h0)
          begin
            done_nxt = 1'b1;                                        // RL19
          end
          else
          begin
            st_nxt       = mmove_pkg::ST_RD_REQ;
            mem_req_nxt  = 1'b1;
            mem_we_nxt   = 1'b0;
            mem_addr_nxt = instr_word1;
            mem_be_nxt   = word_be(instr_word1[1:0],
                                   instr_word0[`MM_CNT_HI:0]);
          end
        end
      end
      mmove_pkg::ST_RD_REQ:
      begin
        if (reg_sel)
        begin
          mem_req_nxt  = 1'b0;                                      // RL12
          reg_re_nxt   = 1'b1;
          reg_addr_nxt = mem_addr_r[6:0];
          st_nxt       = mmove_pkg::ST_RD_REG;
        end
        else if (mem_ack)
        begin
          rd_step = 1'b1;
        end
      end
      mmove_pkg::ST_RD_REG:
      begin
        rd_data = reg_rdata;                                        // RL12
        rd_step = 1'b1;
      end
      mmove_pkg::ST_WR_LOAD:
      begin
        buf_pop       = 1'b1;                                       // RL6
        st_nxt        = mmove_pkg::ST_WR_REQ;
        mem_req_nxt   = 1'b1;
        mem_we_nxt    = 1'b1;
        mem_addr_nxt  = dst_r;
        mem_be_nxt    = buf_head[35:32];
        mem_wdata_nxt = buf_head[31:0];
      end
      mmove_pkg::ST_WR_REQ:
      begin
        if (reg_sel)
        begin
          mem_req_nxt   = 1'b0;
          reg_we_nxt    = (mem_addr_r[6:0] != `MM_FBR_INDEX); // RL12 RL13
          reg_addr_nxt  = mem_addr_r[6:0];
          reg_wdata_nxt = mem_wdata_r;
          st_nxt        = mmove_pkg::ST_WR_REG;
        end
        else if (mem_ack)
        begin
          wr_step = 1'b1;
        end
      end
      mmove_pkg::ST_WR_REG:
      begin
        wr_step = 1'b1;
      end
    endcase

    buf_push = rd_step;                                             // RL6
    buf_in   = {mem_be_r, rd_data};
    if (rd_step)
    begin
      src_nxt  = src_adv;
      rcnt_nxt = rcnt_adv;
      bcnt_nxt = bcnt_r + 1'b1;
      if ((rcnt_adv == 24'h0) || (bcnt_r == BW'(BURST_WORDS - 1)))
      begin
        mem_req_nxt = 1'b0;
        st_nxt      = mmove_pkg::ST_WR_LOAD;
      end
      else
      begin
        mem_req_nxt  = 1'b1;
        mem_addr_nxt = src_adv;
        mem_be_nxt   = word_be(src_adv[1:0], rcnt_adv);
        st_nxt       = mmove_pkg::ST_RD_REQ;
      end
    end
    if (wr_step)
    begin
      dst_nxt = next_word(dst_r);
      if (!buf_empty)
      begin
        buf_pop       = 1'b1;
        mem_req_nxt   = 1'b1;
        mem_addr_nxt  = next_word(dst_r);
        mem_be_nxt    = buf_head[35:32];
        mem_wdata_nxt = buf_head[31:0];
        st_nxt        = mmove_pkg::ST_WR_REQ;
      end
      else if (rcnt_r == 24'h0)
      begin
        mem_req_nxt = 1'b0;
        done_nxt    = 1'b1;                                         // RL7
        st_nxt      = mmove_pkg::ST_IDLE;
      end
      else
      begin
        mem_req_nxt  = 1'b1;                                        // RL7
        mem_we_nxt   = 1'b0;
        mem_addr_nxt = src_r;
        mem_be_nxt   = word_be(src_r[1:0], rcnt_r);
        bcnt_nxt     = '0;
        st_nxt       = mmove_pkg::ST_RD_REQ;
      end
    end
    busy_nxt = (st_nxt != mmove_pkg::ST_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st_r        <= mmove_pkg::ST_IDLE;
      src_r       <= 32'h0;
      dst_r       <= 32'h0;
      rcnt_r      <= 24'h0;
      bcnt_r      <= '0;
      mem_req_r   <= 1'b0;
      mem_we_r    <= 1'b0;
      mem_addr_r  <= 32'h0;
      mem_be_r    <= 4'h0;
      mem_wdata_r <= 32'h0;
      reg_re_r    <= 1'b0;
      reg_we_r    <= 1'b0;
      reg_addr_r  <= 7'h00;
      reg_wdata_r <= 32'h0;
      done_r      <= 1'b0;
      illegal_r   <= 1'b0;
      busy_r      <= 1'b0;
    end
    else
    begin
      st_r        <= st_nxt;
      src_r       <= src_nxt;
      dst_r       <= dst_nxt;
      rcnt_r      <= rcnt_nxt;
      bcnt_r      <= bcnt_nxt;
      mem_req_r   <= mem_req_nxt;
      mem_we_r    <= mem_we_nxt;
      mem_addr_r  <= mem_addr_nxt;
      mem_be_r    <= mem_be_nxt;
      mem_wdata_r <= mem_wdata_nxt;
      reg_re_r    <= reg_re_nxt;
      reg_we_r    <= reg_we_nxt;
      reg_addr_r  <= reg_addr_nxt;
      reg_wdata_r <= reg_wdata_nxt;
      done_r      <= done_nxt;
      illegal_r   <= illegal_nxt;
      busy_r      <= busy_nxt;
    end
  end

  assign busy          = busy_r;
  assign next_fetch    = done_r;
  assign illegal_instr = illegal_r;
  assign mem_req       = mem_req_r;
  assign mem_we        = mem_we_r;
  assign mem_addr      = mem_addr_r;
  assign mem_be        = mem_be_r;
  assign mem_wdata     = mem_wdata_r;
  assign reg_re        = reg_re_r;
  assign reg_we        = reg_we_r;
  assign reg_addr      = reg_addr_r;
  assign reg_wdata     = reg_wdata_r;

endmodule

// ---- design/mmove_defines.svh ----
// constants of the memory-to-memory move engine
`ifndef MMOVE_DEFINES_SVH
`define MMOVE_DEFINES_SVH

`define MM_OPCODE        2'h3
`define MM_OP_HI         31
`define MM_OP_LO         30
`define MM_RSVD_HI       29
`define MM_RSVD_LO       24
`define MM_CNT_HI        23
`define MM_CNT_W         24
`define MM_REG_IDX_W     7
`define MM_FBR_INDEX     7'h08
`define MM_BURST_WORDS   8
`define MM_ENTRY_W       36

`endif

// ---- design/mmove_pkg.sv ----
// types of the memory-to-memory move engine
package mmove_pkg;

  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_RD_REQ,
    ST_RD_REG,
    ST_WR_LOAD,
    ST_WR_REQ,
    ST_WR_REG
  } state_t;

endpackage

// ---- design/burst_buf.sv ----
// burst buffer holding read words until they are written out
`timescale 1ns/1ps

module burst_buf #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_data,
  input  wire logic             pop,
  output logic      [WIDTH-1:0] head_data,
  output logic                  full,
  output logic                  empty
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    wp_nxt;
  logic [AW-1:0]    rp_r;
  logic [AW-1:0]    rp_nxt;
  logic [AW:0]      cnt_r;
  logic [AW:0]      cnt_nxt;
  logic             do_push;
  logic             do_pop;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    do_push = push && (cnt_r != (AW+1)'(DEPTH));
    do_pop  = pop && (cnt_r != '0);
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    if (do_push)
    begin
      wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
    end
    if (do_pop)
    begin
      rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
    end
    cnt_nxt = cnt_r + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (do_push)
    begin
      mem[wp_r] <= push_data;
    end
  end

  assign head_data = mem[rp_r];
  assign full      = (cnt_r == (AW+1)'(DEPTH));
  assign empty     = (cnt_r == '0);

endmodule

// ---- test/mmove_sva.sv ----
// assertion checker of the memory move engine
`timescale 1ns/1ps
module mmove_sva #(
  parameter int BURST_WORDS = 8
) (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        start,
  input wire logic [31:0] instr_word0,
  input wire logic [31:0] instr_word1,
  input wire logic [31:0] instr_word2,
  input wire logic        busy,
  input wire logic        next_fetch,
  input wire logic        illegal_instr,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic        mem_ack,
  input wire logic        reg_sel,
  input wire logic        reg_re,
  input wire logic        reg_we,
  input wire logic [6:0]  reg_addr
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  logic take;
  logic same;
  assign take = start && !busy;
  assign same = instr_word1[1:0] == instr_word2[1:0];
  //////////////////////////////////////////////////////////////////////////
  a_rsvd_illegal: assert property (
    take && instr_word0[29:24] != 6'h0 |=> illegal_instr && !busy)
    else $error("reserved bits accepted");
  a_align_illegal: assert property (
    take && instr_word0[31:24] == 8'hc0 && !same |=> illegal_instr)
    else $error("misaligned move accepted");
  a_opcode_check: assert property (
    take && instr_word0[31:30] != 2'h3 |=> illegal_instr && !mem_req)
    else $error("wrong opcode accepted");
  a_zero_count: assert property (
    take && instr_word0 == 32'hc0000000 && same
    |=> next_fetch && !mem_req && !busy)
    else $error("zero count not finished at once");
  a_first_read: assert property (
    take && instr_word0[31:24] == 8'hc0 && instr_word0[23:0] != 24'h0
    && same |=> mem_req && !mem_we && mem_addr == $past(instr_word1))
    else $error("first read not at source");
  // the edge that ends a reset still sees the request from before it
  a_req_hold: assert property (
    !sys_rst && mem_req && !mem_ack && !reg_sel
    |=> mem_req && $stable(mem_addr))
    else $error("request dropped before answer");
  a_fbr_locked: assert property (
    mem_req && mem_we && reg_sel && mem_addr[6:0] == 7'h08 |=> !reg_we)
    else $error("first byte register written");
  a_reg_index: assert property (
    !sys_rst && mem_req && reg_sel && !mem_we
    |=> reg_re && reg_addr == 7'($past(mem_addr)))
    else $error("register read index wrong");
  c_illegal: cover property (illegal_instr);
  c_reg_write: cover property (reg_we);
  c_mem_write: cover property (mem_req && mem_we && mem_ack);
endmodule

// ---- test/mem_model.sv ----
// memory and register window on the far side of the move engine
`timescale 1ns/1ps
module mem_model (
  input wire logic        sys_clk,
  input wire logic        stall,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [3:0]  mem_be,
  input wire logic [31:0] mem_wdata,
  output logic     [31:0] mem_rdata,
  output logic            mem_ack,
  output logic            reg_sel,
  input wire logic        reg_re,
  input wire logic        reg_we,
  input wire logic [6:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic     [31:0] reg_rdata
);
  logic [31:0] mem [0:63];
  logic [6:0]  wr_idx;
  logic [31:0] wr_data;
  int          wr_cnt = 0;
  initial mem_ack = 1'b0;
  // top of the address space decodes as the register window
  assign reg_sel = mem_req && mem_addr[31:28] == 4'hf;
  // outside the answer cycle the data lines never show the word
  assign mem_rdata = mem_ack ? mem[mem_addr[7:2]] : ~mem[mem_addr[7:2]];
  assign reg_rdata = reg_re ? {25'h0, reg_addr} ^ 32'h5a5a0000 : 32'hffffffff;
  task automatic fill();
    for (int a = 0; a < 256; a++)
      mem[a[7:2]][8*a[1:0] +: 8] = 8'(a) ^ 8'h5a;
    wr_cnt = 0;
  endtask
  always @(posedge sys_clk)
  begin
    mem_ack <= mem_req && !reg_sel && !mem_ack && !stall;
    if (mem_req && mem_we && mem_ack)
      for (int i = 0; i < 4; i++)
        if (mem_be[i])
          mem[mem_addr[7:2]][8*i +: 8] <= mem_wdata[8*i +: 8];
    if (reg_we)
    begin
      wr_idx <= reg_addr;
      wr_data <= reg_wdata;
      wr_cnt <= wr_cnt + 1;
    end
  end
endmodule

// ---- test/memory_to_memory_move_tb.sv ----
// self-checking bench of the memory move engine
`timescale 1ns/1ps
module memory_to_memory_move_tb;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        start = 1'b0;
  logic [31:0] instr_word0 = 32'h0;
  logic [31:0] instr_word1 = 32'h0;
  logic [31:0] instr_word2 = 32'h0;
  logic        stall = 1'b0;
  logic        slow = 1'b0;
  logic        busy, next_fetch, illegal_instr, mem_req, mem_we, mem_ack;
  logic [31:0] mem_addr, mem_wdata, mem_rdata, reg_wdata, reg_rdata;
  logic [3:0]  mem_be;
  logic [6:0]  reg_addr;
  logic        reg_sel, reg_re, reg_we, ill;
  int          error_cnt = 0;
  int          check_count = 0;
  int          reqs;
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    stall <= slow && !stall;
  memory_to_memory_move #(.BURST_WORDS(8)) i_dut (.sys_clk, .sys_rst,
    .start, .instr_word0, .instr_word1, .instr_word2, .busy, .next_fetch,
    .illegal_instr, .mem_req, .mem_we, .mem_addr, .mem_be, .mem_wdata,
    .mem_rdata, .mem_ack, .reg_sel, .reg_re, .reg_we, .reg_addr,
    .reg_wdata, .reg_rdata);
  mem_model i_mem (.sys_clk, .stall, .mem_req, .mem_we, .mem_addr, .mem_be,
    .mem_wdata, .mem_rdata, .mem_ack, .reg_sel, .reg_re, .reg_we,
    .reg_addr, .reg_wdata, .reg_rdata);
  //////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] mb(input int a);
    return {24'h0, i_mem.mem[a[7:2]][8*a[1:0] +: 8]};
  endfunction
  function automatic logic [31:0] pat(input int a);
    return {24'h0, 8'(a) ^ 8'h5a};
  endfunction
  task automatic issue(input logic [31:0] w0, w1, w2);
    @(posedge sys_clk);
    start <= 1'b1;
    instr_word0 <= w0;
    instr_word1 <= w1;
    instr_word2 <= w2;
    @(posedge sys_clk);
    start <= 1'b0;
  endtask
  task automatic go(input logic [31:0] w0, w1, w2);
    int n;
    issue(w0, w1, w2);
    reqs = 0;
    // look right after the taking edge: the one-cycle answers stand there
    for (n = 0; n < 3000; n++)
    begin
      #1;
      reqs += int'(mem_req);
      if (next_fetch || illegal_instr)
        break;
      @(posedge sys_clk);
    end
    ill = illegal_instr;
    if (n == 3000)
    begin
      error_cnt++;
      $display("wrong value at %0t: move never finished", $time);
      complete_run();
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_copy(input logic [23:0] n, input int s, d);
    i_mem.fill();
    go({8'hc0, n}, 32'(s), 32'(d));
    chk(32'(ill), 32'h0);
    for (int k = -1; k <= int'(n); k++)
      chk(mb(d + k), (k < 0 || k == int'(n)) ? pat(d + k) : pat(s + k));
  endtask
  task automatic t_zero();
    go(32'hc0000000, 32'h10, 32'h90);
    chk(32'(ill), 32'h0);
    chk(32'(reqs), 32'h0);
  endtask
  task automatic t_bad();
    logic [31:0] w [3] = '{32'h80000004, 32'hc1000004, 32'hc0000004};
    logic [31:0] s [3] = '{32'h10, 32'h10, 32'h11};
    for (int i = 0; i < 3; i++)
    begin
      i_mem.fill();
      go(w[i], s[i], 32'h90);
      chk(32'(ill), 32'h1);
      chk(32'(reqs), 32'h0);
      chk(mb(32'h90), pat(32'h90));
    end
  endtask
  task automatic t_reg();
    i_mem.fill();
    go(32'hc0000004, 32'hf0000010, 32'h40);
    chk(i_mem.mem[16], 32'h5a5a0010);
    go(32'hc0000004, 32'h40, 32'hf000000c);
    chk(32'(i_mem.wr_idx), 32'hc);
    chk(i_mem.wr_data, 32'h5a5a0010);
    go(32'hc0000004, 32'h40, 32'hf0000008);
    chk(32'(i_mem.wr_cnt), 32'h1);
    go(32'hc0000004, 32'h41, 32'hf000000c);
    chk(32'(ill), 32'h1);
  endtask
  task automatic t_abort();
    issue(32'hc0ffffff, 32'h0, 32'h80);
    repeat (30) @(posedge sys_clk);
    #1;
    chk(32'(busy), 32'h1);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1;
    chk({30'h0, busy, mem_req}, 32'h0);
  endtask
  initial
  begin
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_copy(24'h6, 32'h2, 32'h82);
    slow <= 1'b1;
    t_copy(24'h29, 32'h13, 32'h93);
    slow <= 1'b0;
    t_zero();
    t_bad();
    t_reg();
    t_abort();
    complete_run();
  end
endmodule

bind memory_to_memory_move mmove_sva #(.BURST_WORDS(BURST_WORDS)) i_sva (
  .sys_clk, .sys_rst, .start, .instr_word0, .instr_word1, .instr_word2,
  .busy, .next_fetch, .illegal_instr, .mem_req, .mem_we, .mem_addr,
  .mem_ack, .reg_sel, .reg_re, .reg_we, .reg_addr);
